// [sio_ch0_pkg.sv]
// Constants, types and register map of the clocked serial channel control block.
// Assumes a single AHB-Lite master and pins resolved by the surroundings from o and oe_n.
// Operation
// - Set ack-detect flag when ack is seen on a clock rise after a transfer.
// - Clear ack-detect on the fall after a start releases busy, when disabled, or reset.
// - Busy enable at 0 stops busy drive from the next clock fall.
// - Busy enable at 1 drives busy from the clock fall after the ack.
// - A transfer start releases busy mode; busy enable keeps its value.
// - Auto-ack set after completion sends ack on next fall; enable stays set.
// - Release, command and ack trigger bits read as zero.
// - Interrupt-timing register holds release and mask control, shows clock pin level.
// - Interrupt-timing register resets to zero and is byte writable.
// - Clock-line level bit 6 is read-only.
// - Clock-line level reads zero while the channel is disabled.
// - Four modes exist: stopped, three-wire, serial-bus and two-wire.
// - Stopped mode performs no transfer and the shift register never shifts.
// - Stopped mode leaves the shift register a plain 8-bit register.
// - Stopped mode returns the three pins to general-purpose port use.
// - Mode register sits at FF60H, byte writable, resets to zero.
// - Mode bit 7 stops the channel at 0 and enables it at 1.
// - Three-wire mode uses clock, data out and data in lines.
// - Auto-ack set before completion sends ack with the ninth clock fall.
package sio_ch0_pkg;

  localparam logic [15:0] ADDR_MODE = 16'hFF60;
  localparam logic [15:0] ADDR_HSK = 16'hFF64;
  localparam logic [15:0] ADDR_ITR = 16'hFF68;
  localparam logic [15:0] ADDR_SHIFT = 16'hFF6C;
  localparam logic [15:0] ADDR_PORT_OUT = 16'hFF70;
  localparam logic [15:0] ADDR_PORT_DIR = 16'hFF74;
  localparam logic [15:0] ADDR_PORT_IN = 16'hFF78;
  localparam logic [15:0] ADDR_STATUS = 16'hFF7C;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] ITR_RST = 8'h00;
  localparam logic [2:0] PORT_RST = 3'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] MODE_WR_MASK = 8'hBF;
  localparam logic [7:0] ITR_WR_MASK = 8'h3F;

  localparam int MODE_EN_BIT = 7;
  localparam int MODE_LSB_BIT = 2;
  localparam int MODE_INTCLK_BIT = 1;
  localparam int HSK_BUSY_OUTPUT_ENABLE_BIT = 7;
  localparam int HSK_ACK_DETECT_FLAG_BIT = 6;
  localparam int HSK_AUTO_ACK_ENABLE_BIT = 5;
  localparam int HSK_ACK_TRIGGER_BIT = 4;
  localparam int HSK_COMMAND_TRIGGER_BIT = 1;
  localparam int HSK_BUS_RELEASE_TRIGGER_BIT = 0;
  localparam int ITR_CLD_BIT = 6;
  localparam int PIN_SCK = 2;
  localparam int PIN_SO = 1;
  localparam int PIN_SI = 0;

  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int HCLK_NS = 50;
  localparam int SCK_PERIOD_NS = 400;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / 2 / HCLK_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

  typedef enum logic [3:0] {
    MODE_STOP = 4'b0001,
    MODE_THREE = 4'b0010,
    MODE_BUS = 4'b0100,
    MODE_TWO = 4'b1000
  } mode_e;

  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drive_s;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
  } ahb_cap_s;

endpackage

// [sio_ch0_ctrl.sv]
// Control and status logic of the 8-bit clocked serial channel with an AHB-Lite register slave.
// Assumes all pin inputs are asynchronous to hclk and are sampled through two flip-flops.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module sio_ch0_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial clock pin
  input wire logic serial_clock_pin_in,
  output sio_ch0_pkg::pin_drive_s serial_clock_pin,
  // Serial data-out pin
  input wire logic serial_out_pin_in,
  output sio_ch0_pkg::pin_drive_s serial_out_pin,
  // Serial data-in pin
  input wire logic serial_in_pin_in,
  output sio_ch0_pkg::pin_drive_s serial_in_pin
);
  import sio_ch0_pkg::*;

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic sck_d_r;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  ahb_cap_s cap_r;
  logic wr_ph_r;
  logic rd_wait_r;
  logic [31:0] hrdata_r;
  logic [7:0] rd_nxt;
  logic [7:0] wd;
  logic accept;
  logic [7:0] mode_r;
  logic busy_output_enable_r;
  logic auto_ack_enable_r;
  logic [5:0] itr_r;
  logic [7:0] shift_r;
  logic [2:0] port_out_r;
  logic [2:0] port_dir_r;
  logic en;
  mode_e mode;
  logic wr_mode;
  logic wr_hsk;
  logic wr_itr;
  logic wr_shift;
  logic start;
  logic xfer_r;
  logic [3:0] cnt_r;
  logic done_r;
  logic so_latch_r;
  logic ack_pend_r;
  logic ack_trigger_pend_r;
  logic ack_out_r;
  logic busy_r;
  logic bsy_stop_pend_r;
  logic ack_detect_flag_r;
  logic ack_detect_flag_clr_pend_r;
  logic din;
  logic out_bit;
  logic so_val;
  logic clk_run;
  logic [3:0] div_r;
  logic sck_gen_r;
  logic clock_line_level;

  // Pin inputs in order clock, data-out, data-in.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sck_d_r <= 1'b1;
    end else begin
      sync1_r <= {serial_clock_pin_in, serial_out_pin_in, serial_in_pin_in};
      sync2_r <= sync1_r;
      sck_d_r <= sync2_r[PIN_SCK];
    end
  end

  assign sck_lvl = sync2_r[PIN_SCK];
  assign sck_rise = sck_lvl & ~sck_d_r;
  assign sck_fall = ~sck_lvl & sck_d_r;

  // Bus slave. Reads take one wait state so that a write just before is always seen.
  // Only the low address half is decoded, so the register map repeats through the upper half.
  assign accept = hsel & hready & htrans[1];
  assign hreadyout = ~rd_wait_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign wd = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_r <= '0;
      wr_ph_r <= 1'b0;
      rd_wait_r <= 1'b0;
    end else begin
      wr_ph_r <= accept & hwrite;
      rd_wait_r <= accept & ~hwrite;
      if (accept) begin
        cap_r.addr <= haddr[15:0];
        cap_r.wr <= hwrite;
      end
    end
  end

  assign wr_mode = wr_ph_r && cap_r.addr == ADDR_MODE;
  assign wr_hsk = wr_ph_r && cap_r.addr == ADDR_HSK;
  assign wr_itr = wr_ph_r && cap_r.addr == ADDR_ITR;
  assign wr_shift = wr_ph_r && cap_r.addr == ADDR_SHIFT;

  assign en = mode_r[MODE_EN_BIT];
  assign clock_line_level = en & sck_lvl;

  // Decode of the operating mode.
  always_comb begin
    if (!en) begin
      mode = MODE_STOP;
    end else if (!mode_r[4]) begin
      mode = MODE_THREE;
    end else if (!mode_r[3]) begin
      mode = MODE_BUS;
    end else begin
      mode = MODE_TWO;
    end
  end

  // Trigger bits and the two unused bits among them read back as zero.
  always_comb begin
    unique case (cap_r.addr)
      ADDR_MODE: rd_nxt = mode_r & MODE_WR_MASK;
      ADDR_HSK: rd_nxt = {busy_output_enable_r, ack_detect_flag_r, auto_ack_enable_r, 5'h00};
      ADDR_ITR: rd_nxt = {1'b0, clock_line_level, itr_r};
      ADDR_SHIFT: rd_nxt = shift_r;
      ADDR_PORT_OUT: rd_nxt = {5'h00, port_out_r};
      ADDR_PORT_DIR: rd_nxt = {5'h00, port_dir_r};
      ADDR_PORT_IN: rd_nxt = {5'h00, sync2_r};
      ADDR_STATUS: rd_nxt = {5'h00, busy_r, done_r, xfer_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_wait_r) begin
      hrdata_r <= {24'h000000, rd_nxt};
    end
  end

  // Software-owned control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= MODE_RST;
      busy_output_enable_r <= 1'b0;
      auto_ack_enable_r <= 1'b0;
      itr_r <= ITR_RST[5:0];
      port_out_r <= PORT_RST;
      port_dir_r <= PORT_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= wd & MODE_WR_MASK;
      end
      if (wr_hsk) begin
        busy_output_enable_r <= wd[HSK_BUSY_OUTPUT_ENABLE_BIT];
        auto_ack_enable_r <= wd[HSK_AUTO_ACK_ENABLE_BIT];
      end
      // The clock-level bit is not stored, so a write cannot reach it.
      if (wr_itr) begin
        itr_r <= wd[5:0];
      end
      if (wr_ph_r && cap_r.addr == ADDR_PORT_OUT) begin
        port_out_r <= wd[2:0];
      end
      if (wr_ph_r && cap_r.addr == ADDR_PORT_DIR) begin
        port_dir_r <= wd[2:0];
      end
    end
  end

  // Writing the shift register starts a transfer only while enabled.
  assign start = wr_shift & en;
  assign din = (mode == MODE_THREE) ? sync2_r[PIN_SI] : sync2_r[PIN_SO];
  assign out_bit = mode_r[MODE_LSB_BIT] ? shift_r[0] : shift_r[7];

  // Shift engine and data-out latch. The latch keeps the last bit sent after a frame,
  // so software must issue a release trigger before the open-drain line can float again.
  // Release and command triggers act only between frames; one written mid-frame is dropped, not queued.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= SHIFT_RST;
      xfer_r <= 1'b0;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
      so_latch_r <= 1'b1;
    end else if (!en) begin
      xfer_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 4'h0;
      if (wr_shift) begin
        shift_r <= wd;
      end
    end else if (start) begin
      shift_r <= wd;
      xfer_r <= 1'b1;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
    end else if (xfer_r) begin
      if (sck_fall) begin
        so_latch_r <= out_bit;
      end
      if (sck_rise) begin
        if (mode_r[MODE_LSB_BIT]) begin
          shift_r <= {din, shift_r[7:1]};
        end else begin
          shift_r <= {shift_r[6:0], din};
        end
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == LAST_BIT) begin
          xfer_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end else if (wr_hsk && wd[HSK_BUS_RELEASE_TRIGGER_BIT]) begin
      so_latch_r <= 1'b1;
    end else if (wr_hsk && wd[HSK_COMMAND_TRIGGER_BIT]) begin
      so_latch_r <= 1'b0;
    end
  end

  // Acknowledge output sequencing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_pend_r <= 1'b0;
      ack_trigger_pend_r <= 1'b0;
      ack_out_r <= 1'b0;
    end else if (!en || start) begin
      ack_pend_r <= 1'b0;
      ack_trigger_pend_r <= 1'b0;
      ack_out_r <= 1'b0;
    end else begin
      if (xfer_r && sck_rise && cnt_r == LAST_BIT && auto_ack_enable_r) begin
        ack_pend_r <= 1'b1;
      end else if (wr_hsk && wd[HSK_AUTO_ACK_ENABLE_BIT] && !auto_ack_enable_r && done_r) begin
        ack_pend_r <= 1'b1;
      end else if (sck_fall && !xfer_r) begin
        ack_pend_r <= 1'b0;
      end
      if (wr_hsk && wd[HSK_ACK_TRIGGER_BIT]) begin
        ack_trigger_pend_r <= 1'b1;
      end else if (sck_fall && !xfer_r) begin
        ack_trigger_pend_r <= 1'b0;
      end
      if (sck_fall && !xfer_r) begin
        ack_out_r <= ack_pend_r | ack_trigger_pend_r;
      end
    end
  end

  // Busy mode follows the acknowledge and ends on the next transfer start.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      bsy_stop_pend_r <= 1'b0;
    end else if (!en) begin
      busy_r <= 1'b0;
      bsy_stop_pend_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b0;
      bsy_stop_pend_r <= 1'b0;
    end else begin
      if (wr_hsk && !wd[HSK_BUSY_OUTPUT_ENABLE_BIT]) begin
        bsy_stop_pend_r <= 1'b1;
      end else if (sck_fall) begin
        bsy_stop_pend_r <= 1'b0;
      end
      if (sck_fall && bsy_stop_pend_r) begin
        busy_r <= 1'b0;
      end else if (sck_fall && ack_out_r && busy_output_enable_r) begin
        busy_r <= 1'b1;
      end
    end
  end

  // Acknowledge detection flag, written only by hardware.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_detect_flag_r <= 1'b0;
      ack_detect_flag_clr_pend_r <= 1'b0;
    end else if (!en) begin
      ack_detect_flag_r <= 1'b0;
      ack_detect_flag_clr_pend_r <= 1'b0;
    end else begin
      if (start) begin
        ack_detect_flag_clr_pend_r <= 1'b1;
      end else if (sck_fall) begin
        ack_detect_flag_clr_pend_r <= 1'b0;
      end
      // A rise and a fall never share a cycle, so a set is never lost to a clear.
      if (done_r && !xfer_r && sck_rise && !din) begin
        ack_detect_flag_r <= 1'b1;
      end else if (sck_fall && ack_detect_flag_clr_pend_r) begin
        ack_detect_flag_r <= 1'b0;
      end
    end
  end

  // Internal clock generator; it idles high and runs only while there is work for it.
  // Stopping only while high keeps every low phase whole, so the far side never sees a runt pulse.
  assign clk_run = en & mode_r[MODE_INTCLK_BIT] & (xfer_r | ack_pend_r | ack_trigger_pend_r | ack_out_r
                   | bsy_stop_pend_r | ack_detect_flag_clr_pend_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 4'h0;
      sck_gen_r <= 1'b1;
    end else if (!clk_run && sck_gen_r) begin
      div_r <= 4'h0;
    end else if (div_r == SCK_HALF_LAST) begin
      div_r <= 4'h0;
      sck_gen_r <= ~sck_gen_r;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // Ack and busy both pull the data line low; the bus modes drive it open-drain.
  assign so_val = so_latch_r & ~ack_out_r & ~busy_r;

  always_comb begin
    serial_clock_pin.o = port_out_r[PIN_SCK];
    serial_clock_pin.oe_n = ~port_dir_r[PIN_SCK];
    serial_out_pin.o = port_out_r[PIN_SO];
    serial_out_pin.oe_n = ~port_dir_r[PIN_SO];
    serial_in_pin.o = port_out_r[PIN_SI];
    serial_in_pin.oe_n = ~port_dir_r[PIN_SI];
    unique case (mode)
      MODE_STOP: begin
        serial_in_pin.o = port_out_r[PIN_SI];
      end
      MODE_THREE: begin
        serial_clock_pin.o = sck_gen_r;
        serial_clock_pin.oe_n = ~mode_r[MODE_INTCLK_BIT];
        serial_out_pin.o = so_val;
        serial_out_pin.oe_n = 1'b0;
        serial_in_pin.o = 1'b0;
        serial_in_pin.oe_n = 1'b1;
      end
      MODE_BUS, MODE_TWO: begin
        serial_clock_pin.o = sck_gen_r;
        serial_clock_pin.oe_n = ~mode_r[MODE_INTCLK_BIT];
        serial_out_pin.o = 1'b0;
        serial_out_pin.oe_n = so_val;
        serial_in_pin.o = 1'b0;
        serial_in_pin.oe_n = 1'b1;
      end
    endcase
  end

endmodule

// [sio_ch0_partner.sv]
// Far-side model: an external controller that clocks the serial line and listens on the data line.
// Assumes the design's pin drives arrive as pin_drive_s; it returns the resolved line levels.
`timescale 1ns/1ns
module sio_ch0_partner (
  // Design drives
  input sio_ch0_pkg::pin_drive_s clk_drv,
  input sio_ch0_pkg::pin_drive_s out_drv,
  input sio_ch0_pkg::pin_drive_s in_drv,
  // Resolved lines
  output logic clk_line,
  output logic data_line,
  output logic in_line
);
  import sio_ch0_pkg::*;
  logic ext_sck = 1'b1;
  logic [9:0] cap = '0;
  // The clock idles high outside frames and the data line has a pull-up.
  assign clk_line = clk_drv.oe_n ? ext_sck : clk_drv.o;
  assign data_line = out_drv.oe_n ? 1'b1 : out_drv.o;
  // The data-in line returns the inverse of the data line, so a received frame differs from the one sent.
  assign in_line = in_drv.oe_n ? ~data_line : in_drv.o;
  task automatic pulses(input int n);
    cap = '0;
    #7;
    for (int i = 0; i < n; i++) begin
      ext_sck = 1'b0;
      #200;
      cap = {cap[8:0], data_line};
      ext_sck = 1'b1;
      #200;
    end
  endtask
endmodule

// [sio_ch0_ctrl_checker.sv]
// Concurrent checks on the ports of the serial channel control block.
// Assumes one AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/1ns
module sio_ch0_ctrl_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic serial_clock_pin_in,
  input sio_ch0_pkg::pin_drive_s serial_clock_pin,
  input wire logic serial_out_pin_in,
  input sio_ch0_pkg::pin_drive_s serial_out_pin,
  input wire logic serial_in_pin_in,
  input sio_ch0_pkg::pin_drive_s serial_in_pin
);
  import sio_ch0_pkg::*;
  ahb_cap_s cap;
  logic cap_act;
  logic en_r;
  logic [2:0] dir_r;
  logic [2:0] out_r;
  logic take;
  logic rd_phase;
  assign take = hsel && hready && htrans[1];
  assign rd_phase = cap_act && !cap.wr && !hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap <= '0;
      cap_act <= 1'b0;
    end else if (hready) begin
      cap <= '{addr: haddr[15:0], wr: hwrite};
      cap_act <= take;
    end
  end
  // Shadow copies of the registers that decide what the pins do in stopped mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r <= 1'b0;
      dir_r <= PORT_RST;
      out_r <= PORT_RST;
    end else if (cap_act && cap.wr && hready) begin
      if (cap.addr == ADDR_MODE) en_r <= hwdata[MODE_EN_BIT];
      if (cap.addr == ADDR_PORT_DIR) dir_r <= hwdata[2:0];
      if (cap.addr == ADDR_PORT_OUT) out_r <= hwdata[2:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp is not OKAY");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write waited");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000) else $error("hrdata upper bits set");
  a_rdata_hold: assert property (!take && !rd_phase |=> $stable(hrdata)) else $error("hrdata moved");
  a_trig_zero: assert property (rd_phase && cap.addr == ADDR_HSK |=> hrdata[4:0] == 5'h00)
    else $error("trigger bits read back");
  a_cld_off: assert property (rd_phase && cap.addr == ADDR_ITR && !en_r |=> hrdata[7:6] == 2'h0)
    else $error("clock level shown while disabled");
  a_mode_ro: assert property (rd_phase && cap.addr == ADDR_MODE |=> hrdata[6] == 1'b0)
    else $error("mode bit 6 not zero");
  a_stop_ports: assert property (!en_r |->
    {serial_clock_pin.oe_n, serial_out_pin.oe_n, serial_in_pin.oe_n} == ~dir_r) else $error("stopped pins not ports");
  a_port_value: assert property (!en_r && dir_r[PIN_SCK] |-> serial_clock_pin.o == out_r[PIN_SCK])
    else $error("port value not on clock pin");
  c_hsk_read: cover property (rd_phase && cap.addr == ADDR_HSK);
  c_data_low: cover property (en_r && !serial_out_pin.oe_n && !serial_out_pin.o);
  c_port_drive: cover property (!en_r && !serial_clock_pin.oe_n);
endmodule
bind sio_ch0_ctrl sio_ch0_ctrl_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin(serial_clock_pin),
  .serial_out_pin_in(serial_out_pin_in), .serial_out_pin(serial_out_pin), .serial_in_pin_in(serial_in_pin_in),
  .serial_in_pin(serial_in_pin));

// [tb_sio_ch0_ctrl.sv]
// Self-checking bench: register accesses over AHB-Lite and frames clocked by the far-side model.
// Assumes the design answers writes at once and reads after one wait cycle.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module tb_sio_ch0_ctrl;
  import sio_ch0_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata;
  pin_drive_s clk_drv, out_drv, in_drv;
  logic clk_line, data_line, in_line;
  logic [7:0] rd;
  logic [7:0] modes [5] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'h00};
  int n_mismatch = 0;
  int samples_checked = 0;
  assign hready = hreadyout;
  initial begin
    forever #25 hclk = ~hclk;
  end
  sio_ch0_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .serial_clock_pin_in(clk_line), .serial_clock_pin(clk_drv), .serial_out_pin_in(data_line),
    .serial_out_pin(out_drv), .serial_in_pin_in(in_line), .serial_in_pin(in_drv));
  sio_ch0_partner partner_u (.clk_drv(clk_drv), .out_drv(out_drv), .in_drv(in_drv),
    .clk_line(clk_line), .data_line(data_line), .in_line(in_line));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hready is looked at on the falling edge so that the rising edge that samples it is never raced.
  task automatic wait_ready();
    do begin
      @(negedge hclk);
      rd = hrdata[7:0];
    end while (hready !== 1'b1);
    @(posedge hclk);
  endtask
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    wait_ready();
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, exp, rd)
  endtask
  task automatic clocks(input int n);
    partner_u.pulses(n);
    @(posedge hclk);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(ADDR_MODE, MODE_RST, "mode reset");
    rchk(ADDR_HSK, 8'h00, "handshake reset");
    rchk(ADDR_ITR, ITR_RST, "timing reset");
    rchk(16'hFF80, 8'h00, "unmapped");
    $display("test reset done");
    foreach (modes[i]) begin
      bus(1'b1, ADDR_MODE, modes[i]);
      rchk(ADDR_MODE, modes[i], "mode select");
    end
    bus(1'b1, ADDR_MODE, 8'h5F);
    rchk(ADDR_MODE, 8'h1F, "mode bit 6");
    bus(1'b1, ADDR_ITR, 8'h70);
    rchk(ADDR_ITR, 8'h30, "timing write");
    bus(1'b1, ADDR_HSK, 8'hFF);
    rchk(ADDR_HSK, 8'hA0, "handshake write");
    bus(1'b1, ADDR_HSK, 8'h00);
    $display("test registers done");
    bus(1'b1, ADDR_SHIFT, 8'hA5);
    rchk(ADDR_SHIFT, 8'hA5, "plain shift reg");
    clocks(8);
    rchk(ADDR_SHIFT, 8'hA5, "no shift stopped");
    rchk(ADDR_STATUS, 8'h00, "no transfer stopped");
    bus(1'b1, ADDR_PORT_DIR, 8'h07);
    bus(1'b1, ADDR_PORT_OUT, 8'h05);
    @(posedge hclk);
    `CHK("port enables", 3'b000, {clk_drv.oe_n, out_drv.oe_n, in_drv.oe_n})
    `CHK("port values", 3'b101, {clk_drv.o, out_drv.o, in_drv.o})
    rchk(ADDR_PORT_DIR, 8'h07, "port dir");
    rchk(ADDR_PORT_IN, 8'h05, "port in");
    bus(1'b1, ADDR_PORT_DIR, 8'h00);
    $display("test stopped done");
    bus(1'b1, ADDR_MODE, 8'h90);
    rchk(ADDR_ITR, 8'h70, "clock level");
    bus(1'b1, ADDR_HSK, 8'hA0);
    bus(1'b1, ADDR_SHIFT, 8'hC3);
    clocks(10);
    `CHK("frame one", 10'h30C, partner_u.cap)
    rchk(ADDR_HSK, 8'hE0, "ack seen");
    bus(1'b1, ADDR_SHIFT, 8'h5A);
    rchk(ADDR_HSK, 8'hE0, "busy enable kept");
    `CHK("busy released", 1'b1, data_line)
    clocks(1);
    rchk(ADDR_HSK, 8'hA0, "ack cleared");
    clocks(9);
    `CHK("frame two", 9'h168, partner_u.cap[8:0])
    bus(1'b1, ADDR_HSK, 8'h21);
    clocks(1);
    `CHK("busy stopped", 1'b1, partner_u.cap[0])
    bus(1'b1, ADDR_HSK, 8'h00);
    bus(1'b1, ADDR_HSK, 8'h20);
    clocks(1);
    `CHK("late ack", 1'b0, partner_u.cap[0])
    rchk(ADDR_HSK, 8'h60, "auto ack kept");
    $display("test frames done");
    bus(1'b1, ADDR_MODE, 8'h00);
    rchk(ADDR_HSK, 8'h20, "disable clears");
    rchk(ADDR_ITR, 8'h30, "level off");
    $display("test disable done");
    bus(1'b1, ADDR_MODE, 8'h80);
    bus(1'b1, ADDR_SHIFT, 8'h96);
    clocks(8);
    `CHK("three-wire out", 8'h96, partner_u.cap[7:0])
    rchk(ADDR_SHIFT, 8'h69, "three-wire in");
    rchk(ADDR_STATUS, 8'h02, "three-wire done");
    bus(1'b1, ADDR_MODE, 8'h82);
    bus(1'b1, ADDR_SHIFT, 8'h3C);
    repeat (120) @(posedge hclk);
    `CHK("clock driven", 1'b0, clk_drv.oe_n)
    rchk(ADDR_SHIFT, 8'hC3, "internal clock in");
    $display("test three-wire done");
    tally_and_finish();
  end
endmodule
